// ---- rtl/ast_pkg.sv ----
// Constants shared by the converter sequencer: register map, fields, timing
package ast_pkg;
  localparam int DATA_W = 10;
  localparam int ACC_W  = 11;
  localparam int SEL_W  = 3;
  localparam int CNT_W  = 9;
  localparam int TMR_W  = 20;
  localparam int CLK_MHZ       = 10;
  localparam int DELAY_STEP_US = 50;
  localparam logic [7:0] ADDR_SETUP  = 8'h00;
  localparam logic [7:0] ADDR_DELAY  = 8'h04;
  localparam logic [7:0] ADDR_SPACE  = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0c;
  localparam logic [7:0] ADDR_MINMAX = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;
  // Setup register fields
  localparam int SET_EN      = 0;
  localparam int SET_SEL_LSB = 1;
  localparam int SET_REF_EXT = 4;
  localparam int SET_CNT_LSB = 5;
  localparam int SET_REPEAT  = 8;
  // Delay register fields
  localparam int DLY_PIN      = 0;
  localparam int DLY_RISING   = 1;
  localparam int DLY_STEP_LSB = 2;
  // Spacing register fields
  localparam int SPC_WAIT_LSB = 0;
  localparam int SPC_B1_LSB   = 4;
  localparam int SPC_B2_LSB   = 6;
  // Result and min/max register fields
  localparam int RES_BUSY    = 31;
  localparam int MM_MAX_LSB  = 16;
  localparam logic [8:0]  SETUP_RST = 9'h000;
  localparam logic [5:0]  DELAY_RST = 6'h00;
  localparam logic [7:0]  SPACE_RST = 8'h00;
  localparam logic [DATA_W-1:0] SAR_MID = 10'h200;
  localparam logic [DATA_W-1:0] MIN_RST = 10'h3ff;

  // Samples per conversion cycle: 1, 4, 8 ... 256
  function automatic logic [CNT_W-1:0] samples(input logic [2:0] code);
    logic [CNT_W:0] n;
    // Shift amount is four bits wide so that code 7 reaches 256 without wrapping
    n = (code == 3'h0) ? 10'h001 : (10'h001 << (4'(code) + 4'h1));
    return n[CNT_W-1:0];
  endfunction

  // Spacing between samples in microseconds
  function automatic int wait_us(input logic [3:0] code);
    case (code)
      4'h0: return 20;
      4'h1: return 40;
      4'h2: return 60;
      4'h3: return 80;
      4'h4: return 160;
      4'h5: return 240;
      4'h6: return 320;
      4'h7: return 640;
      4'h8: return 1280;
      4'h9: return 1920;
      4'ha: return 2560;
      4'hb: return 5120;
      4'hc: return 10240;
      4'hd: return 15360;
      default: return 20480;
    endcase
  endfunction

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ARM  = 6'b000010,
    ST_DLY  = 6'b000100,
    ST_CONV = 6'b001000,
    ST_WAIT = 6'b010000,
    ST_END  = 6'b100000
  } ast_state_e;
endpackage

// ---- rtl/ast_adc_sequencer.sv ----
// Converter sequencer: trigger control, SAR engine, min/max/average unit, Wishbone registers
// How it works
// - A 10-step successive approximation search yields each 10-bit sample.
// - The 3-bit input select field drives the single eight-way multiplexer select.
// - Inputs are analog one, analog two, current, thermistor, die, backup, bus, battery.
// - Spacing register fields pick 0/10/50/60 uA bias for each analog pin.
// - Thermistor and analog-one bias turn on whenever input power is detected.
// - External reference selection switches the reference regulator off, otherwise on.
// - Trigger control starts the engine and hands each finished word to the ALU.
// - At cycle end results move to result registers and status updates.
// - Internal mode triggers the next sample after delay and spacing times.
// - With pin trigger enabled, an edge on the trigger pin starts conversion.
// - Minimum, maximum and average are computed for every conversion cycle.
// - The running result sits in an 11-bit accumulator whose top bit is always zero.
// - The result register is loaded only at the end of a cycle.
// - Cycles hold one or several samples and may run once or repeat.
// - Samples per cycle are programmable from one up to 256.
// - A low-to-high write of the enable bit starts a cycle.
// - A cycle end with repeat off or enable cleared drives the busy bit low and, if unmasked, interrupt low.
// - After the pin delay, conversion starts only if the pin stays active.
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module ast_adc_sequencer #(
  parameter int CYC_PER_US = ast_pkg::CLK_MHZ
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          input_power_i,
  input  wire logic                          trigger_capable_io_pin_i,
  input  wire logic                          cmp_i,
  output logic      [ast_pkg::SEL_W-1:0]     mux_sel_o,
  output logic                               conv_start_o,
  output logic      [ast_pkg::DATA_W-1:0]    dac_code_o,
  output logic      [1:0]                    bias_one_sel_o,
  output logic      [1:0]                    bias_two_sel_o,
  output logic                               thermistor_bias_en_o,
  output logic                               analog_one_bias_en_o,
  output logic                               ref_ldo_en_o,
  output logic                               int_n_o
);
  localparam int DW = ast_pkg::DATA_W;

  // Three-stage synchronisers for power detect (bit 0) and trigger pin (bit 1)
  logic [1:0] async_in;
  logic [1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
  assign async_in = {trigger_capable_io_pin_i, input_power_i};
  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1_q[g] <= 1'b0;
        s2_q[g] <= 1'b0;
        s3_q[g] <= 1'b0;
      end else begin
        s1_q[g] <= async_in[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
      end
    end
    assign lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
  end

  function automatic logic [31:0] wmask(input logic [3:0] sel);
    logic [31:0] m;
    for (int i = 0; i < 4; i++) m[i*8 +: 8] = {8{sel[i]}};
    return m;
  endfunction

  ast_pkg::ast_state_e  state_q, state_d;
  logic [8:0]           setup_q, setup_d;
  logic [5:0]           delay_q, delay_d;
  logic [7:0]           space_q, space_d;
  logic                 mask_q, mask_d, en_prev_q, en_prev_d;
  logic                 busy_q, busy_d, int_n_q, int_n_d, start_q, start_d;
  logic [ast_pkg::ACC_W-1:0]  acc_q, acc_d, res_q, res_d;
  logic [DW-1:0]        min_q, min_d, max_q, max_d, minr_q, minr_d, maxr_q, maxr_d;
  logic [DW-1:0]        dac_q, dac_d;
  logic [3:0]           bit_q, bit_d;
  logic [ast_pkg::CNT_W-1:0]  cnt_q, cnt_d;
  logic [ast_pkg::TMR_W-1:0]  tmr_q, tmr_d;
  logic                 ack_q, ack_d, ref_q, ref_d, bias_q, bias_d;
  logic [31:0]          rdat_q, rdat_d;
  logic                 pin_act, pin_edge, rd_wr, wr, en_rise, pin_mode;
  logic [DW-1:0]        code, trial;
  logic [ast_pkg::ACC_W-1:0]  sum;
  logic [31:0]          m;

  assign pin_mode = delay_q[ast_pkg::DLY_PIN];
  assign pin_act  = lvl_q[1] == delay_q[ast_pkg::DLY_RISING];
  assign pin_edge = (lvl_d[1] != lvl_q[1]) && (lvl_d[1] == delay_q[ast_pkg::DLY_RISING]);
  assign rd_wr    = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr       = rd_wr && wb_we_i;
  assign m        = wmask(wb_sel_i);

  function automatic logic [ast_pkg::TMR_W-1:0] dly_cycles(input logic [3:0] step);
    int c;
    c = int'(step) * ast_pkg::DELAY_STEP_US * CYC_PER_US;
    return ast_pkg::TMR_W'(c);
  endfunction

  function automatic logic [ast_pkg::TMR_W-1:0] wait_cycles(input logic [3:0] wc);
    int c;
    c = ast_pkg::wait_us(wc) * CYC_PER_US;
    return ast_pkg::TMR_W'(c);
  endfunction

  always_comb begin
    state_d   = state_q;
    setup_d   = setup_q;
    delay_d   = delay_q;
    space_d   = space_q;
    mask_d    = mask_q;
    en_prev_d = setup_q[ast_pkg::SET_EN];
    busy_d    = busy_q;
    int_n_d   = !(!busy_q && !mask_q && int_n_q == 1'b0);
    start_d   = 1'b0;
    acc_d     = acc_q;
    res_d     = res_q;
    min_d     = min_q;
    max_d     = max_q;
    minr_d    = minr_q;
    maxr_d    = maxr_q;
    dac_d     = dac_q;
    bit_d     = bit_q;
    cnt_d     = cnt_q;
    tmr_d     = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
    ack_d     = rd_wr;
    rdat_d    = 32'h0000_0000;
    ref_d     = !setup_q[ast_pkg::SET_REF_EXT];
    bias_d    = lvl_q[0];
    en_rise   = setup_q[ast_pkg::SET_EN] && !en_prev_q;
    code      = cmp_i ? dac_q : (dac_q & ~(DW'(1) << bit_q));
    trial     = code | (DW'(1) << (bit_q - 4'h1));
    sum       = {1'b0, acc_q[DW-1:0]} + {1'b0, code};
    if (rd_wr) begin
      case (wb_adr_i)
        ast_pkg::ADDR_SETUP:  rdat_d = {23'h0, setup_q};
        ast_pkg::ADDR_DELAY:  rdat_d = {26'h0, delay_q};
        ast_pkg::ADDR_SPACE:  rdat_d = {24'h0, space_q};
        ast_pkg::ADDR_RESULT: rdat_d = {busy_q, 20'h0, res_q};
        ast_pkg::ADDR_MINMAX: rdat_d = {6'h0, maxr_q, 6'h0, minr_q};
        ast_pkg::ADDR_MASK:   rdat_d = {31'h0, mask_q};
        default:              rdat_d = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        ast_pkg::ADDR_SETUP: setup_d = 9'((setup_q & m[8:0]) ^ setup_q | (wb_dat_i[8:0] & m[8:0]));
        ast_pkg::ADDR_DELAY: delay_d = 6'((delay_q & ~m[5:0]) | (wb_dat_i[5:0] & m[5:0]));
        ast_pkg::ADDR_SPACE: space_d = 8'((space_q & ~m[7:0]) | (wb_dat_i[7:0] & m[7:0]));
        ast_pkg::ADDR_MASK:  mask_d  = m[0] ? wb_dat_i[0] : mask_q;
        default: ;
      endcase
    end
    case (state_q)
      ast_pkg::ST_IDLE: begin
        if (en_rise) begin
          busy_d  = 1'b1;
          int_n_d = 1'b1;
          acc_d   = '0;
          min_d   = ast_pkg::MIN_RST;
          max_d   = '0;
          cnt_d   = '0;
          tmr_d   = dly_cycles(delay_q[ast_pkg::DLY_STEP_LSB +: 4]);
          state_d = pin_mode ? ast_pkg::ST_ARM : ast_pkg::ST_DLY;
        end
      end
      ast_pkg::ST_ARM: begin
        if (pin_edge) begin
          tmr_d   = dly_cycles(delay_q[ast_pkg::DLY_STEP_LSB +: 4]);
          state_d = ast_pkg::ST_DLY;
        end
      end
      ast_pkg::ST_DLY: begin
        if (tmr_q == '0) begin
          if (pin_mode && !pin_act) begin
            state_d = ast_pkg::ST_ARM;
          end else begin
            start_d = 1'b1;
            dac_d   = ast_pkg::SAR_MID;
            bit_d   = 4'(DW - 1);
            state_d = ast_pkg::ST_CONV;
          end
        end
      end
      ast_pkg::ST_CONV: begin
        if (bit_q != 4'h0) begin
          dac_d = trial;
          bit_d = bit_q - 4'h1;
        end else begin
          dac_d = code;
          acc_d = (cnt_q == '0) ? {1'b0, code} : {1'b0, sum[DW:1]};
          min_d = (code < min_q) ? code : min_q;
          max_d = (code > max_q) ? code : max_q;
          cnt_d = cnt_q + 1'b1;
          if (cnt_d == ast_pkg::samples(setup_q[ast_pkg::SET_CNT_LSB +: 3])) begin
            state_d = ast_pkg::ST_END;
          end else begin
            tmr_d   = wait_cycles(space_q[ast_pkg::SPC_WAIT_LSB +: 4]);
            state_d = ast_pkg::ST_WAIT;
          end
        end
      end
      ast_pkg::ST_WAIT: begin
        if (tmr_q == '0) begin
          start_d = 1'b1;
          dac_d   = ast_pkg::SAR_MID;
          bit_d   = 4'(DW - 1);
          state_d = ast_pkg::ST_CONV;
        end
      end
      ast_pkg::ST_END: begin
        res_d  = acc_q;
        minr_d = min_q;
        maxr_d = max_q;
        acc_d  = '0;
        min_d  = ast_pkg::MIN_RST;
        max_d  = '0;
        cnt_d  = '0;
        if (setup_q[ast_pkg::SET_REPEAT] && setup_q[ast_pkg::SET_EN]) begin
          tmr_d   = dly_cycles(delay_q[ast_pkg::DLY_STEP_LSB +: 4]);
          state_d = pin_mode ? ast_pkg::ST_ARM : ast_pkg::ST_DLY;
        end else begin
          busy_d  = 1'b0;
          int_n_d = mask_q;
          state_d = ast_pkg::ST_IDLE;
        end
      end
      default: state_d = ast_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= ast_pkg::ST_IDLE;
      setup_q   <= ast_pkg::SETUP_RST;
      delay_q   <= ast_pkg::DELAY_RST;
      space_q   <= ast_pkg::SPACE_RST;
      mask_q    <= 1'b1;
      en_prev_q <= 1'b0;
      busy_q    <= 1'b0;
      int_n_q   <= 1'b1;
      start_q   <= 1'b0;
      acc_q     <= '0;
      res_q     <= '0;
      min_q     <= ast_pkg::MIN_RST;
      max_q     <= '0;
      minr_q    <= '0;
      maxr_q    <= '0;
      dac_q     <= '0;
      bit_q     <= '0;
      cnt_q     <= '0;
      tmr_q     <= '0;
      ack_q     <= 1'b0;
      rdat_q    <= 32'h0000_0000;
      ref_q     <= 1'b1;
      bias_q    <= 1'b0;
      lvl_q     <= 2'h0;
    end else begin
      state_q   <= state_d;
      setup_q   <= setup_d;
      delay_q   <= delay_d;
      space_q   <= space_d;
      mask_q    <= mask_d;
      en_prev_q <= en_prev_d;
      busy_q    <= busy_d;
      int_n_q   <= int_n_d;
      start_q   <= start_d;
      acc_q     <= acc_d;
      res_q     <= res_d;
      min_q     <= min_d;
      max_q     <= max_d;
      minr_q    <= minr_d;
      maxr_q    <= maxr_d;
      dac_q     <= dac_d;
      bit_q     <= bit_d;
      cnt_q     <= cnt_d;
      tmr_q     <= tmr_d;
      ack_q     <= ack_d;
      rdat_q    <= rdat_d;
      ref_q     <= ref_d;
      bias_q    <= bias_d;
      lvl_q     <= lvl_d;
    end
  end

  assign wb_dat_o             = rdat_q;
  assign wb_ack_o             = ack_q;
  assign mux_sel_o            = setup_q[ast_pkg::SET_SEL_LSB +: ast_pkg::SEL_W];
  assign conv_start_o         = start_q;
  assign dac_code_o           = dac_q;
  assign bias_one_sel_o       = space_q[ast_pkg::SPC_B1_LSB +: 2];
  assign bias_two_sel_o       = space_q[ast_pkg::SPC_B2_LSB +: 2];
  assign thermistor_bias_en_o = bias_q;
  assign analog_one_bias_en_o = bias_q;
  assign ref_ldo_en_o         = ref_q;
  assign int_n_o              = int_n_q;

  // Checks
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_q |=> !ack_q) else $error("ack held too long");
  a_ref_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ref_q == !$past(setup_q[ast_pkg::SET_REF_EXT])) else $error("ldo enable wrong");
  a_bias_power: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 bias_q == $past(lvl_q[0])) else $error("bias enable wrong");
  a_start_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ast_pkg::ST_IDLE && en_rise) |=> busy_q) else $error("cycle not started");
  a_sar_len: assert property (@(posedge clk_i) disable iff (rst_i)
    start_q |-> (state_q == ast_pkg::ST_CONV) [*5] ##1 (state_q == ast_pkg::ST_CONV) [*5]
    ##1 state_q != ast_pkg::ST_CONV) else $error("sar length wrong");
  a_result_end: assert property (@(posedge clk_i) disable iff (rst_i)
    (res_q != $past(res_q)) |-> $past(state_q) == ast_pkg::ST_END) else $error("result early");
  a_done_int: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(busy_q) |-> int_n_q == mask_q) else $error("interrupt wrong");
  a_pin_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ast_pkg::ST_DLY && tmr_q == '0 && pin_mode && !pin_act) |=> !start_q)
    else $error("start without active pin");
  a_min_le_max: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(busy_q) |-> minr_q <= maxr_q) else $error("min above max");
  c_single: cover property (@(posedge clk_i) $fell(busy_q) && minr_q == maxr_q);
  c_pin: cover property (@(posedge clk_i) state_q == ast_pkg::ST_ARM ##[1:1000] start_q);
  c_repeat: cover property (@(posedge clk_i)
    state_q == ast_pkg::ST_END && setup_q[ast_pkg::SET_REPEAT]);
endmodule // ast_adc_sequencer

// ---- tb/ast_analog_model.sv ----
// Analog far side: held input per channel and the comparator
`timescale 1ns/1ps
module ast_analog_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        clr_i,
  input  wire logic [2:0]  mux_sel_i,
  input  wire logic        conv_start_i,
  input  wire logic [9:0]  dac_code_i,
  input  wire logic [79:0] levels_i,
  input  wire logic [9:0]  ramp_i,
  output logic             cmp_o
);
  logic [9:0] held_q;
  logic [9:0] step_q;
  logic [9:0] level;
  // Channel n of the level table is input n+1; a ramp steps each later sample
  assign level = levels_i[mux_sel_i*10 +: 10] + step_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      held_q <= 10'h000;
      step_q <= 10'h000;
    end else if (conv_start_i) begin
      held_q <= level;
      step_q <= step_q + ramp_i;
    end
  end
  // Open switch tracks during the start pulse, then the held value is compared
  assign cmp_o = ((conv_start_i ? level : held_q) >= dac_code_i);
endmodule // ast_analog_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, pwr = 1'b0, pin = 1'b0, clr = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd, mid, res, mm;
  logic        ack, cmp, start, th_en, a1_en, ldo, irq_n;
  logic [2:0]  mux;
  logic [9:0]  dac, prev, ramp = 10'h000;
  logic [1:0]  b1, b2;
  logic [79:0] levels = 80'h0;
  logic [10:0] acc;
  int          failures = 0, cmp_count = 0, starts = 0, n0;

  ast_adc_sequencer #(.CYC_PER_US(1)) ast_adc_sequencer_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .input_power_i(pwr), .trigger_capable_io_pin_i(pin), .cmp_i(cmp), .mux_sel_o(mux),
    .conv_start_o(start), .dac_code_o(dac), .bias_one_sel_o(b1), .bias_two_sel_o(b2),
    .thermistor_bias_en_o(th_en), .analog_one_bias_en_o(a1_en), .ref_ldo_en_o(ldo),
    .int_n_o(irq_n));

  ast_analog_model ast_analog_model_i (
    .clk_i(clk_i), .rst_i(rst_i), .clr_i(clr), .mux_sel_i(mux), .conv_start_i(start),
    .dac_code_i(dac), .levels_i(levels), .ramp_i(ramp), .cmp_o(cmp));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (start === 1'b1) starts <= starts + 1;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One classic cycle; held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    chk("ack idle", 32'h0, {31'h0, ack});
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (irq_n !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    while (irq_n !== 1'b0 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    chk("done level", 32'h0, {31'h0, irq_n});
  endtask

  // Clear enable, set it, read mid-cycle, wait for the end, read results
  task automatic run(input logic [31:0] setup);
    wb(ast_pkg::ADDR_SETUP, 1'b1, setup);
    wb(ast_pkg::ADDR_SETUP, 1'b1, setup | 32'h1);
    wb(ast_pkg::ADDR_RESULT, 1'b0, 32'h0);
    mid = rd;
    wait_done();
    wb(ast_pkg::ADDR_RESULT, 1'b0, 32'h0);
    res = rd;
    wb(ast_pkg::ADDR_MINMAX, 1'b0, 32'h0);
    mm = rd;
  endtask

  task automatic t_reset();
    chk("ldo enable", 32'h1, {31'h0, ldo});
    chk("irq idle", 32'h1, {31'h0, irq_n});
    wb(ast_pkg::ADDR_SETUP, 1'b0, 32'h0);
    chk("setup reset", {23'h0, ast_pkg::SETUP_RST}, rd);
    wb(ast_pkg::ADDR_MASK, 1'b0, 32'h0);
    chk("mask reset", 32'h1, rd);
    wb(8'h18, 1'b1, 32'hffff_ffff);
    wb(8'h18, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(ast_pkg::ADDR_RESULT, 1'b1, 32'h7ff);
    wb(ast_pkg::ADDR_RESULT, 1'b0, 32'h0);
    chk("result read-only", 32'h0, rd);
  endtask

  task automatic t_static();
    for (int c = 0; c < 4; c++) begin
      wb(ast_pkg::ADDR_SPACE, 1'b1, {24'h0, 2'(3 - c), 2'(c), 4'h0});
      ticks(2);
      chk("bias one", 32'(c), {30'h0, b1});
      chk("bias two", 32'(3 - c), {30'h0, b2});
    end
    pwr <= 1'b1;
    ticks(6);
    chk("bias enables on", 32'h3, {30'h0, th_en, a1_en});
    pwr <= 1'b0;
    ticks(6);
    chk("bias enables off", 32'h0, {30'h0, th_en, a1_en});
    wb(ast_pkg::ADDR_SETUP, 1'b1, 32'h10);
    ticks(2);
    chk("ldo external", 32'h0, {31'h0, ldo});
    wb(ast_pkg::ADDR_SETUP, 1'b1, 32'h0);
    ticks(2);
    chk("ldo internal", 32'h1, {31'h0, ldo});
    ticks(20);
  endtask

  task automatic t_channels();
    wb(ast_pkg::ADDR_MASK, 1'b1, 32'h0);
    for (int ch = 0; ch < 8; ch++) begin
      levels[ch*10 +: 10] = 10'h025 + 10'(ch) * 10'h079;
    end
    for (int ch = 0; ch < 8; ch++) begin
      prev = levels[ch*10 +: 10];
      run(32'(ch) << ast_pkg::SET_SEL_LSB);
      chk("mux select", 32'(ch), {29'h0, mux});
      chk("result", {22'h0, prev}, res & 32'h8000_07ff);
      chk("min max", {6'h0, prev, 6'h0, prev}, mm);
    end
  endtask

  task automatic t_average();
    logic [9:0] s;
    ramp = 10'h028;
    levels[9:0] = 10'h384;
    clr <= 1'b1;
    ticks(1);
    clr <= 1'b0;
    run(32'h20);
    acc = 11'h384;
    for (int k = 1; k < 4; k++) begin
      s = 10'h384 + 10'(k) * 10'h028;
      acc = (acc + {1'b0, s}) >> 1;
    end
    chk("average", {21'h0, acc}, res & 32'h8000_07ff);
    chk("min max", {6'h0, s, 6'h0, 10'h384}, mm);
    ramp = 10'h000;
    levels[9:0] = 10'h005;
    clr <= 1'b1;
    ticks(1);
    clr <= 1'b0;
    run(32'h0);
    chk("cleared min max", {6'h0, 10'h005, 6'h0, 10'h005}, mm);
  endtask

  task automatic t_counts();
    prev = 10'h005;
    for (int c = 0; c < 8; c++) begin
      levels[9:0] = 10'h003 + 10'(c) * 10'h032;
      n0 = starts;
      run(32'(c) << ast_pkg::SET_CNT_LSB);
      chk("busy mid-cycle", {1'b1, 20'h0, 1'b0, prev}, mid & 32'h8000_07ff);
      chk("samples", (c == 0) ? 32'h1 : (32'h1 << (c + 1)), 32'(starts - n0));
      prev = levels[9:0];
      chk("result", {22'h0, prev}, res & 32'h8000_07ff);
    end
  endtask

  task automatic t_pin();
    wb(ast_pkg::ADDR_DELAY, 1'b1, 32'h7);
    wb(ast_pkg::ADDR_SETUP, 1'b1, 32'h0);
    wb(ast_pkg::ADDR_SETUP, 1'b1, 32'h1);
    n0 = starts;
    ticks(80);
    chk("armed no start", 32'h0, 32'(starts - n0));
    pin <= 1'b1;
    ticks(10);
    pin <= 1'b0;
    ticks(120);
    chk("pin fell early", 32'h0, 32'(starts - n0));
    pin <= 1'b1;
    wait_done();
    chk("pin start", 32'h1, 32'(starts - n0));
    wb(ast_pkg::ADDR_DELAY, 1'b1, 32'h5);
    wb(ast_pkg::ADDR_SETUP, 1'b1, 32'h0);
    wb(ast_pkg::ADDR_SETUP, 1'b1, 32'h1);
    n0 = starts;
    ticks(80);
    chk("falling armed", 32'h0, 32'(starts - n0));
    pin <= 1'b0;
    wait_done();
    chk("falling start", 32'h1, 32'(starts - n0));
    wb(ast_pkg::ADDR_DELAY, 1'b1, 32'h0);
  endtask

  task automatic t_repeat();
    wb(ast_pkg::ADDR_SETUP, 1'b1, 32'h0);
    wb(ast_pkg::ADDR_SETUP, 1'b1, 32'h101);
    n0 = starts;
    ticks(400);
    chk("repeat irq", 32'h1, {31'h0, irq_n});
    chk("repeat cycles", 32'h1, {31'h0, (starts - n0) >= 3});
    wb(ast_pkg::ADDR_SETUP, 1'b1, 32'h0);
    ticks(100);
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_static();
    t_channels();
    t_average();
    t_counts();
    t_pin();
    t_repeat();
    close_out();
  end

  initial begin
    #8_000_000;
    failures++;
    close_out();
  end
endmodule // tb_top
